// file: hw/chp_host_port.v
/*
  Host readout port: a sector data port and a decoded video port, each fed by a
  16-bit word stream through a FIFO and drained as 32-bit long words.
  Assumes the host always reads full long words and discards an odd tail half.
*/
`timescale 1ns/1ps
`include "chp_port_map.vh"

module chp_fifo #(
    parameter WIDTH = `CHP_LONG_W,
    parameter DEPTH = `CHP_FIFO_DEPTH,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             i_clk_sys,
    input  wire             i_rstn,
    // Fill side
    input  wire             i_valid,
    output wire             o_ready,
    input  wire [WIDTH-1:0] i_data,
    // Drain side
    output wire             o_valid,
    input  wire             i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    function [AW-1:0] chp_inc;
        input [AW-1:0] p;
        begin
            chp_inc = (p == DEPTH - 1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    assign o_ready = (cnt_q != DEPTH);
    assign o_valid = (cnt_q != 0);
    assign o_data  = mem[rd_q];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem[wr_q] <= i_data;
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= chp_inc(wr_q);
            end
            if (pop)
            begin
                rd_q <= chp_inc(rd_q);
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

module chp_lane (
    // Clock and reset
    input  wire                   i_clk_sys,
    input  wire                   i_rstn,
    // Word stream in
    input  wire                   i_wvalid,
    output wire                   o_wready,
    input  wire [`CHP_HALF_W-1:0] i_word,
    input  wire                   i_last,
    // Host long-word read
    input  wire                   i_rd,
    output reg                    o_rvalid,
    output reg  [`CHP_LONG_W-1:0] o_rdata
);
    reg                   half_q;
    reg [`CHP_HALF_W-1:0] hi_q;
    wire                  pk_valid;
    wire [`CHP_LONG_W-1:0] pk_data;
    wire                  pk_ready;
    wire                  f_valid;
    wire [`CHP_LONG_W-1:0] f_data;
    wire                  take;
    wire                  odd_tail;

    assign take     = i_wvalid && o_wready;
    assign odd_tail = !half_q && i_last;
    // Pair ready once the second word arrives or a lone last word closes it
    assign pk_valid = i_wvalid && (half_q || i_last);
    assign pk_data  = half_q ? {hi_q, i_word} : {i_word, {2{`CHP_FILL_W}}};
    // Stall on a full FIFO for any word, so a registered ready never overruns it
    assign o_wready = pk_ready;

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            half_q <= 1'b0;
            hi_q   <= {`CHP_HALF_W{1'b0}};
        end
        else if (take)
        begin
            if (half_q || odd_tail)
            begin
                half_q <= 1'b0;
            end
            else
            begin
                hi_q   <= i_word;
                half_q <= 1'b1;
            end
        end
    end

    chp_fifo #(
        .WIDTH (`CHP_LONG_W),
        .DEPTH (`CHP_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_valid   (pk_valid),
        .o_ready   (pk_ready),
        .i_data    (pk_data),
        .o_valid   (f_valid),
        .i_ready   (i_rd),
        .o_data    (f_data)
    );

    // One pop per long-word read, two stream words per pop, one for an odd tail word
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rvalid <= 1'b0;
            o_rdata  <= {`CHP_LONG_W{1'b0}};
        end
        else
        begin
            o_rvalid <= i_rd && f_valid;
            if (i_rd && f_valid)
            begin
                o_rdata <= f_data;
            end
        end
    end
endmodule

module chp_host_port (
    // Clock and reset
    input  wire                   i_clk_sys,
    input  wire                   i_rstn,
    // Sector data stream in
    input  wire                   i_dat_wvalid,
    output reg                    o_dat_wready,
    input  wire [`CHP_HALF_W-1:0] i_dat_word,
    input  wire                   i_dat_last,
    // Decoded video stream in
    input  wire                   i_vid_wvalid,
    output reg                    o_vid_wready,
    input  wire [`CHP_HALF_W-1:0] i_vid_word,
    input  wire                   i_vid_last,
    // Host reads of sector_data_port
    input  wire                   i_dat_rd,
    output wire                   o_dat_rvalid,
    output wire [`CHP_LONG_W-1:0] o_dat_rdata,
    // Host reads of decoded_video_port
    input  wire                   i_vid_rd,
    output wire                   o_vid_rvalid,
    output wire [`CHP_LONG_W-1:0] o_vid_rdata
);
    wire dat_rdy;
    wire vid_rdy;

    // Ready outputs registered; source words are taken only on registered ready
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_dat_wready <= 1'b0;
            o_vid_wready <= 1'b0;
        end
        else
        begin
            o_dat_wready <= dat_rdy && !(o_dat_wready && i_dat_wvalid);
            o_vid_wready <= vid_rdy && !(o_vid_wready && i_vid_wvalid);
        end
    end

    // Read strobe is identical whether from DMA or software loops
    chp_lane u_dat (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_wvalid  (i_dat_wvalid && o_dat_wready),
        .o_wready  (dat_rdy),
        .i_word    (i_dat_word),
        .i_last    (i_dat_last),
        .i_rd      (i_dat_rd),
        .o_rvalid  (o_dat_rvalid),
        .o_rdata   (o_dat_rdata)
    );

    // Same lane logic for the video port
    chp_lane u_vid (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_wvalid  (i_vid_wvalid && o_vid_wready),
        .o_wready  (vid_rdy),
        .i_word    (i_vid_word),
        .i_last    (i_vid_last),
        .i_rd      (i_vid_rd),
        .o_rvalid  (o_vid_rvalid),
        .o_rdata   (o_vid_rdata)
    );
endmodule

// file: hw/chp_port_map.vh
/*
  Constants for the host readout port: word and long-word widths, FIFO depth.
  Assumes inclusion by bare name from the port module file.
*/
`ifndef CHP_PORT_MAP_VH
`define CHP_PORT_MAP_VH
`define CHP_HALF_W     16
`define CHP_LONG_W     32
`define CHP_FIFO_DEPTH 8
`define CHP_FILL_W     8'h00
`endif

// file: test/chp_host_model.sv
/* Host reader model: one full long-word read per call.
   Assumes the port answers in the cycle after the strobe. */
`timescale 1ns/1ps
module chp_host_model (
    input  wire        i_clk_sys,
    output reg         o_rd,
    input  wire        i_rvalid,
    input  wire [31:0] i_rdata
);
    initial o_rd = 1'b0;
    // Long-word read, same for DMA or software, odd tail half dropped
    task rd_long(input bit odd, output reg [31:0] d, output reg ok);
        begin
            @(negedge i_clk_sys) o_rd = 1'b1;
            @(negedge i_clk_sys) o_rd = 1'b0;
            ok = i_rvalid;
            d = odd ? {i_rdata[31:16], 16'h0000} : i_rdata;
        end
    endtask
endmodule

// file: test/chp_host_port_assertions.sv
/* Port checker for the host readout block.
   Assumes one clock domain and binding to chp_host_port. */
`timescale 1ns/1ps
module chp_port_chk (
    input wire        i_clk_sys,
    input wire        i_rstn,
    input wire        i_dat_wvalid,
    input wire        o_dat_wready,
    input wire        i_vid_wvalid,
    input wire        o_vid_wready,
    input wire        i_dat_rd,
    input wire        o_dat_rvalid,
    input wire [31:0] o_dat_rdata,
    input wire        i_vid_rd,
    input wire        o_vid_rvalid,
    input wire [31:0] o_vid_rdata
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_dat_read_cause: assert property (o_dat_rvalid |-> $past(i_dat_rd))
        else $error("data answer without read");
    a_vid_read_cause: assert property (o_vid_rvalid |-> $past(i_vid_rd))
        else $error("video answer without read");
    a_dat_rdata_hold: assert property ($changed(o_dat_rdata) |-> o_dat_rvalid)
        else $error("data word moved without read");
    a_vid_rdata_hold: assert property ($changed(o_vid_rdata) |-> o_vid_rvalid)
        else $error("video word moved without read");
    a_dat_take_gap: assert property (i_dat_wvalid && o_dat_wready |=> !o_dat_wready)
        else $error("data ready held after take");
    a_vid_take_gap: assert property (i_vid_wvalid && o_vid_wready |=> !o_vid_wready)
        else $error("video ready held after take");
    c_dat_read: cover property (o_dat_rvalid);
    c_vid_read: cover property (o_vid_rvalid);
    c_dat_stall: cover property (i_dat_wvalid && !o_dat_wready);
endmodule
bind chp_host_port chp_port_chk chp_port_chk_i (.i_clk_sys, .i_rstn, .i_dat_wvalid,
    .o_dat_wready, .i_vid_wvalid, .o_vid_wready, .i_dat_rd, .o_dat_rvalid, .o_dat_rdata,
    .i_vid_rd, .o_vid_rvalid, .o_vid_rdata);

// file: test/cd_host_data_port_bench.sv
/* Bench for the host readout port, one host model per port.
   Assumes words may be offered from the second edge after reset. */
`timescale 1ns/1ps
module cd_host_data_port_bench;
    reg         clk;
    reg         rstn;
    reg  [1:0]  wv;
    reg         lst;
    reg  [15:0] dw;
    wire [1:0]  wr, rd, rv;
    wire [31:0] dr, vr;
    int         err_total = 0;
    int         cmp_count = 0;
    chp_host_port chp_host_port_i (.i_clk_sys(clk), .i_rstn(rstn), .i_dat_wvalid(wv[0]),
        .o_dat_wready(wr[0]), .i_dat_word(dw), .i_dat_last(lst), .i_vid_wvalid(wv[1]),
        .o_vid_wready(wr[1]), .i_vid_word(dw), .i_vid_last(lst), .i_dat_rd(rd[0]),
        .o_dat_rvalid(rv[0]), .o_dat_rdata(dr), .i_vid_rd(rd[1]), .o_vid_rvalid(rv[1]),
        .o_vid_rdata(vr));
    chp_host_model dat_host_i (.i_clk_sys(clk), .o_rd(rd[0]), .i_rvalid(rv[0]),
        .i_rdata(dr));
    chp_host_model vid_host_i (.i_clk_sys(clk), .o_rd(rd[1]), .i_rvalid(rv[1]),
        .i_rdata(vr));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task summarize;
        begin
            $display("errors %0d compares %0d", err_total, cmp_count);
            if (err_total == 0 && cmp_count > 0)
            begin
                $display("bench passed");
            end
            else
            begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            cmp_count++;
            if (g !== e)
            begin
                err_total++;
                $display("[ERR] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task push(input int p, input [15:0] w, input bit l);
        int n;
        begin
            @(negedge clk) wv[p] = 1'b1;
            dw = w;
            lst = l;
            for (n = 0; n < 50 && wr[p] !== 1'b1; n++) @(negedge clk);
            if (n == 50)
            begin
                err_total++;
                summarize;
            end
            @(negedge clk) wv[p] = 1'b0;
        end
    endtask
    task rdq(input int p, input bit odd, input bit okx, input [31:0] e);
        reg [31:0] d;
        reg        ok;
        begin
            if (p)
            begin
                vid_host_i.rd_long(odd, d, ok);
            end
            else
            begin
                dat_host_i.rd_long(odd, d, ok);
            end
            chk({31'h0, ok}, {31'h0, okx});
            if (okx) chk(d, e);
        end
    endtask
    task s_pair(input int p);
        begin
            push(p, 16'h1234, 1'b0);
            push(p, 16'hABCD, 1'b1);
            rdq(p, 1'b0, 1'b1, 32'h1234ABCD);
        end
    endtask
    task s_odd;
        begin
            push(0, 16'h1111, 1'b0);
            push(0, 16'h2222, 1'b0);
            push(0, 16'h3333, 1'b1);
            rdq(0, 1'b0, 1'b1, 32'h11112222);
            rdq(0, 1'b1, 1'b1, 32'h33330000);
            rdq(0, 1'b0, 1'b0, 32'h0);
        end
    endtask
    task s_fill;
        int i;
        begin
            for (i = 0; i < 16; i++) push(0, 16'h0100 + i[15:0], i == 15);
            @(negedge clk);
            chk({31'h0, wr[0]}, 32'h0);
            for (i = 0; i < 8; i++)
                rdq(0, 1'b0, 1'b1, {16'h0100 + 16'(2 * i), 16'h0101 + 16'(2 * i)});
        end
    endtask
    initial
    begin
        wv = 2'b00;
        dw = 16'h0000;
        lst = 1'b0;
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        s_pair(0);
        s_pair(1);
        s_odd;
        s_fill;
        summarize;
    end
endmodule
